// ---- common/framer_pkg.sv ----
package framer_pkg;
   // -------------------------------------------------------------
   // Clock and link timing
   // -------------------------------------------------------------
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned BAUD_0 = 38400;
   localparam int unsigned BAUD_1 = 57600;
   localparam int unsigned BAUD_2 = 115200;
   localparam int unsigned BAUD_3 = 230400;
   localparam int unsigned DATA_BITS = 8;
   localparam int unsigned TIMEOUT_S = 4;
   localparam int unsigned PING_GAP_US = 2000;
   localparam int unsigned TIMEOUT_CYCLES_DEF = TIMEOUT_S * CLK_HZ;
   localparam int unsigned PING_GAP_CYCLES_DEF = PING_GAP_US * (CLK_HZ / 1_000_000);
   // -------------------------------------------------------------
   // Framing constants
   // -------------------------------------------------------------
   localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
   localparam logic [7:0] ASCII_P = 8'h50;
   localparam logic [7:0] ASCII_K = 8'h4b;
   localparam logic [15:0] TYPE_PING = 16'h504b;
   localparam logic [15:0] TYPE_NAK = 16'h1515;
   localparam logic [15:0] TYPE_WRITE = 16'h5746;
   localparam logic [15:0] TYPE_SET = 16'h5346;
   localparam logic [15:0] TYPE_READ = 16'h5246;
   localparam logic [15:0] TYPE_GET = 16'h4746;
   localparam logic [7:0] NAK_LEN = 8'h02;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [2:0] STOP_IDX = 3'h1;
   // -------------------------------------------------------------
   // State types
   // -------------------------------------------------------------
   typedef enum logic [2:0] {
      R_HUNT1 = 3'b000, R_HUNT2 = 3'b001, R_TYPEH = 3'b010,
      R_TYPEL = 3'b011, R_LEN = 3'b100, R_PAY = 3'b101,
      R_CRCH = 3'b110, R_CRCL = 3'b111
   } rx_state_t;
   typedef enum logic [2:0] {
      G_IDLE = 3'b000, G_RAW = 3'b001, G_HDR = 3'b010, G_CNT = 3'b011,
      G_ITEM = 3'b100, G_NAK = 3'b101, G_CRC = 3'b110
   } gen_state_t;
   typedef enum logic [1:0] {
      K_PING = 2'b00, K_FIELD = 2'b01, K_NAK = 2'b10
   } reply_kind_t;
   // Bit period in clock cycles, rounded to nearest
   function automatic logic [15:0] baud_div(input logic [1:0] sel);
      int unsigned b;
      case (sel)
         2'h0: b = BAUD_0;
         2'h1: b = BAUD_1;
         2'h2: b = BAUD_2;
         default: b = BAUD_3;
      endcase
      return 16'((CLK_HZ + b / 2) / b);
   endfunction
   // One CRC-CCITT byte step, MSB first
   function automatic logic [15:0] crc_step(input logic [15:0] c,
                                            input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {d, 8'h00};
      for (int i = 0; i < 8; i++) begin
         r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
      end
      return r;
   endfunction
endpackage

// ---- logic/uart_packet_link_framer.sv ----
`timescale 1ns/1ps
module uart_packet_link_framer
   import framer_pkg::*;
#(
   parameter int unsigned FIELD_COUNT = 8,
   parameter logic [15:0] FIELD_DEFAULT = 16'h0000,
   parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYCLES_DEF,
   parameter int unsigned PING_GAP_CYCLES = PING_GAP_CYCLES_DEF
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic por_i,
   input wire logic [1:0] baud_sel_i,
   input wire logic rx_i,
   output logic tx_o,
   output logic [FIELD_COUNT*16-1:0] fields_o
);
   localparam int FW = (FIELD_COUNT > 1) ? $clog2(FIELD_COUNT) : 1;
   localparam int unsigned FLAST = FIELD_COUNT - 1;

   // -------------------------------------------------------------
   // Serial receiver
   // -------------------------------------------------------------
   logic s1, s2, s3, rx_lvl;
   logic rx_busy, byte_stb;
   logic [15:0] rx_cnt;
   logic [3:0] rx_bit;
   logic [7:0] rx_sh, rx_byte;
   wire [15:0] div = baud_div(baud_sel_i);

   // Three-stage sync; level changes once stages two and three agree
   always_ff @(posedge clk_i) begin
      s1 <= rx_i;
      s2 <= s1;
      s3 <= s2;
      if (rst_i)
         rx_lvl <= 1'b1;
      else if (s2 == s3)
         rx_lvl <= s3;
   end

   // Mid-bit sampling of start, eight data bits and stop
   always_ff @(posedge clk_i) begin
      byte_stb <= 1'b0;
      if (rst_i) begin
         rx_busy <= 1'b0;
         rx_cnt <= '0;
         rx_bit <= '0;
         rx_sh <= '0;
         rx_byte <= '0;
      end else if (!rx_busy) begin
         if (!rx_lvl) begin
            rx_busy <= 1'b1;
            rx_cnt <= div >> 1;
            rx_bit <= '0;
         end
      end else if (rx_cnt != '0) begin
         rx_cnt <= rx_cnt - 16'h0001;
      end else begin
         rx_cnt <= div - 16'h0001;
         rx_bit <= rx_bit + 4'h1;
         if (rx_bit == 4'h0 && rx_lvl)
            rx_busy <= 1'b0;                 // False start
         else if (rx_bit == 4'(DATA_BITS + 1)) begin
            rx_busy <= 1'b0;
            byte_stb <= rx_lvl;
            rx_byte <= rx_sh;
         end else if (rx_bit != 4'h0)
            rx_sh <= {rx_lvl, rx_sh[7:1]};
      end
   end

   // -------------------------------------------------------------
   // Packet parser
   // -------------------------------------------------------------
   rx_state_t rx_state;
   logic [15:0] rx_type, rx_crc, cur_id;
   logic [7:0] rx_len, pay_left, num_fields, crc_hi, val_hi;
   logic [1:0] grp_idx;
   logic first_pay, bad_id;
   logic [FIELD_COUNT-1:0] mask;
   logic [15:0] stage [FIELD_COUNT];
   logic [31:0] tmo_cnt, gap_cnt;

   wire is_wr = (rx_type == TYPE_WRITE) || (rx_type == TYPE_SET);
   wire is_rd = (rx_type == TYPE_READ) || (rx_type == TYPE_GET);
   wire [1:0] grp_last = is_wr ? 2'h3 : 2'h1;
   wire [9:0] need_len = 10'(num_fields) * (is_wr ? 10'h4 : 10'h2) + 10'h1;
   wire len_ok = (need_len == {2'h0, rx_len}) && (rx_len != 8'h00);
   wire [15:0] pay_id = {cur_id[15:8], rx_byte};
   wire [15:0] pay_val = {val_hi, rx_byte};
   wire at_crc_lo = byte_stb && rx_state == R_CRCL;
   wire crc_ok = ({crc_hi, rx_byte} == rx_crc);
   wire timeout = (rx_state != R_HUNT1)
                  && (tmo_cnt >= TIMEOUT_CYCLES - 1);
   wire ping_raw = (rx_state == R_LEN) && (rx_type == TYPE_PING)
                   && !byte_stb && (gap_cnt >= PING_GAP_CYCLES - 1);
   wire gen_idle;
   wire dispatch = at_crc_lo && crc_ok && gen_idle;
   wire fire_raw = ping_raw && gen_idle;

   // Completion window and inter-byte gap counters
   always_ff @(posedge clk_i) begin
      if (rst_i || rx_state == R_HUNT1)
         tmo_cnt <= '0;
      else
         tmo_cnt <= tmo_cnt + 32'h1;
      if (rst_i || byte_stb)
         gap_cnt <= '0;
      else if (gap_cnt != 32'hffff_ffff)
         gap_cnt <= gap_cnt + 32'h1;
   end

   // Framing state, running CRC and staged field payload
   always_ff @(posedge clk_i) begin
      if (rst_i || timeout || ping_raw) begin
         rx_state <= R_HUNT1;
      end else if (byte_stb) begin
         if (rx_state inside {R_TYPEH, R_TYPEL, R_LEN, R_PAY})
            rx_crc <= crc_step(rx_crc, rx_byte);
         case (rx_state)
            R_HUNT1: if (rx_byte == PREAMBLE_BYTE) rx_state <= R_HUNT2;
            R_HUNT2: begin
               rx_crc <= CRC_INIT;
               rx_state <= (rx_byte == PREAMBLE_BYTE) ? R_TYPEH : R_HUNT1;
            end
            R_TYPEH: begin
               rx_type[15:8] <= rx_byte;
               rx_state <= R_TYPEL;
            end
            R_TYPEL: begin
               rx_type[7:0] <= rx_byte;
               rx_state <= R_LEN;
            end
            R_LEN: begin
               rx_len <= rx_byte;
               pay_left <= rx_byte;
               first_pay <= 1'b1;
               grp_idx <= '0;
               bad_id <= 1'b0;
               mask <= '0;
               num_fields <= '0;
               rx_state <= (rx_byte == 8'h00) ? R_CRCH : R_PAY;
            end
            R_PAY: begin
               pay_left <= pay_left - 8'h01;
               first_pay <= 1'b0;
               if (first_pay)
                  num_fields <= rx_byte;
               else begin
                  grp_idx <= (grp_idx == grp_last) ? 2'h0 : grp_idx + 2'h1;
                  if (grp_idx == 2'h0) cur_id[15:8] <= rx_byte;
                  if (grp_idx == 2'h1) cur_id <= pay_id;
                  if (grp_idx == 2'h2) val_hi <= rx_byte;
                  if (grp_idx == 2'h1 && is_rd) begin
                     if (pay_id < 16'(FIELD_COUNT))
                        mask[FW'(pay_id)] <= 1'b1;
                     else
                        bad_id <= 1'b1;
                  end
                  if (grp_idx == 2'h3 && is_wr) begin
                     if (cur_id < 16'(FIELD_COUNT)) begin
                        mask[FW'(cur_id)] <= 1'b1;
                        stage[FW'(cur_id)] <= pay_val;
                     end else
                        bad_id <= 1'b1;
                  end
               end
               if (pay_left == 8'h01) rx_state <= R_CRCH;
            end
            R_CRCH: begin
               crc_hi <= rx_byte;
               rx_state <= R_CRCL;
            end
            R_CRCL: rx_state <= R_HUNT1;
            default: rx_state <= R_HUNT1;
         endcase
      end
   end

   // -------------------------------------------------------------
   // Field stores: stored defaults and working copy
   // -------------------------------------------------------------
   logic [15:0] nv [FIELD_COUNT];
   logic [15:0] vol [FIELD_COUNT];
   wire field_cmd = is_wr || is_rd;
   wire good_field = field_cmd && len_ok && !bad_id;
   wire commit_nv = dispatch && good_field && rx_type == TYPE_WRITE;
   wire commit_vol = dispatch && good_field && rx_type == TYPE_SET;
   wire [FIELD_COUNT*16-1:0] nv_flat, stage_flat, mask_wide;

   // Power-up sets defaults; system reset reloads the working copy
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < FIELD_COUNT; i++) begin
         if (por_i)
            nv[i] <= FIELD_DEFAULT;
         else if (commit_nv && mask[i])
            nv[i] <= stage[i];
         if (rst_i || por_i)
            vol[i] <= por_i ? FIELD_DEFAULT : nv[i];
         else if (commit_vol && mask[i])
            vol[i] <= stage[i];
      end
   end

   genvar g;
   generate
      for (g = 0; g < FIELD_COUNT; g++) begin : g_out
         assign fields_o[g*16 +: 16] = vol[g];
         assign nv_flat[g*16 +: 16] = nv[g];
         assign stage_flat[g*16 +: 16] = stage[g];
         assign mask_wide[g*16 +: 16] = {16{mask[g]}};
      end
   endgenerate

   // -------------------------------------------------------------
   // Reply generator
   // -------------------------------------------------------------
   gen_state_t gen;
   reply_kind_t kind;
   logic [15:0] rep_type, tx_crc;
   logic [7:0] rep_len, rep_cnt;
   logic [FIELD_COUNT-1:0] rep_mask;
   logic rep_nv, rep_val;
   logic [2:0] sub;
   logic [FW-1:0] fptr;
   logic [7:0] gen_byte;
   wire buf_ready;

   // Population count of the requested field set
   function automatic logic [7:0] ones(input logic [FIELD_COUNT-1:0] m);
      logic [7:0] n;
      n = '0;
      for (int i = 0; i < FIELD_COUNT; i++) n = n + 8'(m[i]);
      return n;
   endfunction

   assign gen_idle = (gen == G_IDLE);
   wire [15:0] item_val = rep_nv ? nv[fptr] : vol[fptr];
   wire [15:0] item_id = 16'(fptr);
   wire skip = (gen == G_ITEM) && !rep_mask[fptr];
   wire push = !gen_idle && !skip && buf_ready;
   wire crc_en = push && gen != G_RAW && gen != G_CRC
                 && !(gen == G_HDR && sub < 3'h2);
   wire [2:0] item_last = rep_val ? 3'h3 : 3'h1;
   wire f_end = (fptr == FW'(FLAST));
   // Header type; a refusal keeps the offending type for its payload
   wire [15:0] hdr_type = (kind == K_NAK) ? TYPE_NAK : rep_type;

   // Byte selection for the current position
   always_comb begin
      case (gen)
         G_RAW: gen_byte = (sub == 3'h0) ? ASCII_P : ASCII_K;
         G_HDR: case (sub)
            3'h0, 3'h1: gen_byte = PREAMBLE_BYTE;
            3'h2: gen_byte = hdr_type[15:8];
            3'h3: gen_byte = hdr_type[7:0];
            default: gen_byte = rep_len;
         endcase
         G_CNT: gen_byte = rep_cnt;
         G_ITEM: case (sub)
            3'h0: gen_byte = item_id[15:8];
            3'h1: gen_byte = item_id[7:0];
            3'h2: gen_byte = item_val[15:8];
            default: gen_byte = item_val[7:0];
         endcase
         G_NAK: gen_byte = (sub == 3'h0) ? rep_type[15:8] : rep_type[7:0];
         G_CRC: gen_byte = (sub == 3'h0) ? tx_crc[15:8] : tx_crc[7:0];
         default: gen_byte = 8'h00;
      endcase
   end

   // Sequencing of reply bytes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gen <= G_IDLE;
         sub <= '0;
         fptr <= '0;
         kind <= K_NAK;
         rep_type <= '0;
         rep_len <= '0;
         rep_cnt <= '0;
         rep_mask <= '0;
         rep_nv <= 1'b0;
         rep_val <= 1'b0;
         tx_crc <= CRC_INIT;
      end else if (gen_idle) begin
         sub <= '0;
         fptr <= '0;
         tx_crc <= CRC_INIT;
         rep_type <= rx_type;
         rep_mask <= mask;
         rep_nv <= (rx_type == TYPE_READ) || (rx_type == TYPE_WRITE);
         rep_val <= is_rd;
         rep_cnt <= ones(mask);
         if (fire_raw)
            gen <= G_RAW;
         else if (dispatch) begin
            gen <= G_HDR;
            if (rx_type == TYPE_PING && rx_len == 8'h00) begin
               kind <= K_PING;
               rep_len <= 8'h00;
            end else if (good_field) begin
               kind <= K_FIELD;
               rep_len <= 8'(ones(mask) * (is_rd ? 8'h4 : 8'h2) + 8'h1);
            end else begin
               kind <= K_NAK;
               rep_len <= NAK_LEN;
            end
         end
      end else if (skip) begin
         fptr <= fptr + FW'(1);
         if (f_end) gen <= G_CRC;
      end else if (push) begin
         if (crc_en) tx_crc <= crc_step(tx_crc, gen_byte);
         sub <= sub + 3'h1;
         case (gen)
            G_RAW: if (sub == STOP_IDX) gen <= G_IDLE;
            G_HDR: if (sub == 3'h4) begin
               sub <= '0;
               gen <= (kind == K_PING) ? G_CRC
                    : (kind == K_NAK) ? G_NAK : G_CNT;
            end
            G_CNT: begin
               sub <= '0;
               gen <= (rep_cnt == 8'h00) ? G_CRC : G_ITEM;
            end
            G_ITEM: if (sub == item_last) begin
               sub <= '0;
               fptr <= fptr + FW'(1);
               if (f_end) gen <= G_CRC;
            end
            G_NAK: if (sub == STOP_IDX) begin
               sub <= '0;
               gen <= G_CRC;
            end
            G_CRC: if (sub == STOP_IDX) gen <= G_IDLE;
            default: gen <= G_IDLE;
         endcase
      end
   end

   // -------------------------------------------------------------
   // Two-entry buffer between generator and transmitter
   // -------------------------------------------------------------
   logic [7:0] buf_mem [2];
   logic wr_ptr, rd_ptr;
   logic [1:0] buf_cnt;
   logic tx_busy;
   assign buf_ready = (buf_cnt != 2'h2);
   wire buf_valid = (buf_cnt != 2'h0);
   wire pop = buf_valid && !tx_busy;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         buf_cnt <= '0;
      end else begin
         if (push) begin
            buf_mem[wr_ptr] <= gen_byte;
            wr_ptr <= ~wr_ptr;
         end
         if (pop) rd_ptr <= ~rd_ptr;
         buf_cnt <= buf_cnt + 2'(push) - 2'(pop);
      end
   end

   // -------------------------------------------------------------
   // Serial transmitter
   // -------------------------------------------------------------
   logic [9:0] tx_sh;
   logic [15:0] tx_cnt;
   logic [3:0] tx_bit;

   // Start bit, eight data bits LSB first, stop bit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_busy <= 1'b0;
         tx_sh <= '1;
         tx_cnt <= '0;
         tx_bit <= '0;
         tx_o <= 1'b1;
      end else if (pop) begin
         tx_busy <= 1'b1;
         tx_sh <= {1'b1, buf_mem[rd_ptr], 1'b0};
         tx_cnt <= div - 16'h0001;
         tx_bit <= '0;
         tx_o <= 1'b0;
      end else if (tx_busy) begin
         if (tx_cnt != '0)
            tx_cnt <= tx_cnt - 16'h0001;
         else if (tx_bit == 4'(DATA_BITS + 1))
            tx_busy <= 1'b0;
         else begin
            tx_cnt <= div - 16'h0001;
            tx_bit <= tx_bit + 4'h1;
            tx_sh <= {1'b1, tx_sh[9:1]};
            tx_o <= tx_sh[1];
         end
      end
   end

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   tx_idle_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !tx_busy |-> tx_o) else $error("tx line low while idle");
   stop_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_busy && tx_bit == 4'h9 |-> tx_o) else $error("stop bit low");
   bit_time_a: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_busy |-> tx_cnt < div) else $error("bit counter beyond period");
   preamble_a: assert property (@(posedge clk_i) disable iff (rst_i)
      push && gen == G_HDR && sub < 3'h2 |-> gen_byte == 8'h55)
      else $error("preamble byte wrong");
   bad_crc_a: assert property (@(posedge clk_i) disable iff (rst_i)
      at_crc_lo && !crc_ok && gen_idle && !fire_raw |=> gen == G_IDLE)
      else $error("reply after bad crc");
   raw_ping_a: assert property (@(posedge clk_i) disable iff (rst_i)
      fire_raw |=> gen == G_RAW && gen_byte == ASCII_P)
      else $error("raw ping not answered");
   full_ping_a: assert property (@(posedge clk_i) disable iff (rst_i)
      dispatch && rx_type == 16'h504b && rx_len == 8'h00
      |=> gen == G_HDR && kind == K_PING) else $error("ping ignored");
   commit_nv_a: assert property (@(posedge clk_i) disable iff (rst_i)
      commit_nv |=> $stable(fields_o)
      && ((nv_flat ^ $past(stage_flat)) & $past(mask_wide)) == '0)
      else $error("write fields touched working copy");
   commit_vol_a: assert property (@(posedge clk_i) disable iff (rst_i)
      commit_vol |=> $stable(nv_flat)) else $error("set fields touched defaults");
   timeout_a: assert property (@(posedge clk_i) disable iff (rst_i)
      timeout |=> rx_state == R_HUNT1) else $error("timeout not honoured");
endmodule

// ---- verification/host_uart_model.sv ----
`timescale 1ns/1ps
// ---------------------------------------------
// Host end of the serial link
// ---------------------------------------------
module host_uart_model #(
   parameter int DIV = 174
) (
   input wire logic clk_i,
   input wire logic tx_i,
   output logic rx_o
);
   logic [7:0] got[$];
   initial rx_o = 1'b1;
   // One character: start, 8 data bits LSB first, stop; line idles high
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      @(posedge clk_i);
      #1;
      for (int i = 0; i < 10; i++) begin
         rx_o = f[i];
         repeat (DIV) @(posedge clk_i);
         #1;
      end
   endtask
   // Collect device characters, sampled in mid-bit
   initial begin
      logic [7:0] b;
      forever begin
         @(negedge tx_i);
         repeat (DIV / 2) @(posedge clk_i);
         for (int i = 0; i < 8; i++) begin
            repeat (DIV) @(posedge clk_i);
            b[i] = tx_i;
         end
         repeat (DIV) @(posedge clk_i);
         if (tx_i === 1'b1) begin
            got.push_back(b);
         end
      end
   end
   // Checksum over header and payload, no final inversion
   function automatic logic [15:0] crc16(input logic [7:0] d[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (d[i]) begin
         c = c ^ {d[i], 8'h00};
         for (int k = 0; k < 8; k++) begin
            c = c[15] ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
         end
      end
      return c;
   endfunction
   // Build a whole packet; bad spoils the checksum on purpose
   task automatic frame(input logic [15:0] typ, input logic [7:0] pay[$],
                        input logic bad, output logic [7:0] p[$]);
      logic [15:0] c;
      p = {typ[15:8], typ[7:0], 8'(pay.size())};
      p = {p, pay};
      c = crc16(p) ^ {15'h0, bad};
      p = {8'h55, 8'h55, p, c[15:8], c[7:0]};
   endtask
   // Characters go back to back, well inside the completion window
   task automatic send_all(input logic [7:0] p[$]);
      foreach (p[i]) begin
         send_byte(p[i]);
      end
   endtask
endmodule

// ---- verification/uart_packet_link_framer_tb_top.sv ----
`timescale 1ns/1ps
// ---------------------------------------------
// Testbench top
// ---------------------------------------------
module uart_packet_link_framer_tb_top;
   import framer_pkg::*;
   localparam int DIV = (CLK_HZ + BAUD_3 / 2) / BAUD_3;
   localparam int WATCHDOG = 95000;
   logic clk_i;
   logic rst_i;
   logic por_i;
   logic [1:0] baud_sel_i;
   logic rx_i;
   logic tx_o;
   logic [127:0] fields_o;
   logic [7:0] pay[$];
   logic [7:0] pkt[$];
   int n_mismatch = 0;
   int checks = 0;
   uart_packet_link_framer #(.TIMEOUT_CYCLES(40000), .PING_GAP_CYCLES(3000))
      u_uart_packet_link_framer (.clk_i(clk_i), .rst_i(rst_i),
      .por_i(por_i), .baud_sel_i(baud_sel_i), .rx_i(rx_i), .tx_o(tx_o),
      .fields_o(fields_o));
   host_uart_model #(.DIV(DIV)) u_host_uart_model (.clk_i(clk_i),
      .tx_i(tx_o), .rx_o(rx_i));
   // 40 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                        input string msg);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t %s seen %h exp %h", $time, msg, seen, exp);
      end
   endtask
   // Wait for a reply of known length, then compare it byte by byte
   task automatic expect_reply(input logic [7:0] exp[$]);
      int t;
      t = 0;
      while (u_host_uart_model.got.size() < exp.size() && t < 30000) begin
         @(posedge clk_i);
         t++;
      end
      check(16'(u_host_uart_model.got.size()), 16'(exp.size()), "count");
      foreach (exp[i]) begin
         if (i < u_host_uart_model.got.size()) begin
            check(16'(u_host_uart_model.got[i]), 16'(exp[i]), "byte");
         end
      end
      u_host_uart_model.got.delete();
   endtask
   // Set-fields with a spoiled checksum: no reply, no change
   task automatic test_bad_crc();
      pay = {8'h01, 8'h00, 8'h02, 8'h11, 8'h11};
      u_host_uart_model.frame(TYPE_SET, pay, 1'b1, pkt);
      u_host_uart_model.send_all(pkt);
      repeat (4000) @(posedge clk_i);
      check(16'(u_host_uart_model.got.size()), 16'h0000, "reply");
      check(fields_o[47:32], 16'h0000, "field after drop");
   endtask
   // Bare ping right after a drop: receiver hunts afresh
   task automatic test_raw_ping();
      pkt = {8'h55, 8'h55, 8'h50, 8'h4b};
      u_host_uart_model.send_all(pkt);
      pkt = {8'h50, 8'h4b};
      expect_reply(pkt);
   endtask
   // Working copy changes at once and is lost over a restart
   task automatic test_set_fields();
      pay = {8'h01, 8'h00, 8'h02, 8'hbe, 8'hef};
      u_host_uart_model.frame(TYPE_SET, pay, 1'b0, pkt);
      u_host_uart_model.send_all(pkt);
      pay = {8'h01, 8'h00, 8'h02};
      u_host_uart_model.frame(TYPE_SET, pay, 1'b0, pkt);
      expect_reply(pkt);
      check(fields_o[47:32], 16'hbeef, "field set");
      check(fields_o[31:16], 16'h0000, "field untouched");
      @(posedge clk_i);
      #1;
      rst_i = 1'b1;
      repeat (2) @(posedge clk_i);
      #1;
      rst_i = 1'b0;
      @(posedge clk_i);
      #1;
      check(fields_o[47:32], 16'h0000, "field after restart");
   endtask
   task automatic test_done();
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Cut a hang short
   initial begin
      repeat (WATCHDOG) @(posedge clk_i);
      n_mismatch++;
      test_done();
   end
   // Main sequence
   initial begin
      rst_i = 1'b1;
      por_i = 1'b1;
      baud_sel_i = 2'h3;
      repeat (2) @(posedge clk_i);
      #1;
      rst_i = 1'b0;
      por_i = 1'b0;
      repeat (4) @(posedge clk_i);
      test_bad_crc();
      test_raw_ping();
      test_set_fields();
      test_done();
   end
endmodule
